// file: design/exec_subset_pkg.sv
// Purpose: shared constants for the instruction execution subset
// Assumes: 14-bit instruction words, 8-bit data path, 13-bit program counter
// Notes:   opcode encodings are this block's own decode map
package exec_subset_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W   = 13;
  localparam int INSTR_W = 14;
  localparam int FADDR_W = 7;
  localparam int CALL_K_W = 11;
  localparam int PAGE_LO_BIT = 3;
  localparam int PAGE_HI_BIT = 4;
  localparam int DEST_BIT = 7;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE  = 8'h01;
  localparam logic [PC_W-1:0]   PC_ONE    = 13'h0001;
  localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
  // opcode matches on the upper bits; watchdog clear matches the whole word
  localparam logic [13:0] OP_WDT_CLEAR = 14'h0064;
  localparam logic [13:0] OP_CLEAR_ACC = 14'h0100;
  localparam logic [5:0]  OP_CLEAR_REG = 6'h01;
  localparam logic [5:0]  OP_COMPL     = 6'h09;
  localparam logic [5:0]  OP_DEC       = 6'h03;
  localparam logic [5:0]  OP_DEC_SKIP  = 6'h0b;
  localparam logic [2:0]  OP_CALL      = 3'h4;
  localparam logic        CLR_REG_D    = 1'b1;

  typedef enum logic [2:0] {
    K_NONE  = 3'b000,
    K_WDT   = 3'b001,
    K_CALL  = 3'b010,
    K_COMPL = 3'b011,
    K_CLEAR_REG_INSTR  = 3'b100,
    K_CLEAR_ACCUM_INSTR  = 3'b101,
    K_DEC   = 3'b110,
    K_DSKIP = 3'b111
  } instr_kind_t;

  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,
    ST_FLUSH = 2'b01
  } exec_state_t;
endpackage

// file: design/exec_subset_decode.sv
// Purpose: classify a 14-bit instruction word into the handled kinds
// Assumes: word is stable during the execute cycle
// Notes:   purely combinational
module exec_subset_decode
  import exec_subset_pkg::*;
(
  input  wire logic [INSTR_W-1:0] instr_i, // instruction word
  output instr_kind_t             kind_o   // decoded kind
);
  always_comb begin
    kind_o = K_NONE;
    if (instr_i == OP_WDT_CLEAR) begin
      kind_o = K_WDT;
    end else if (instr_i[13:7] == OP_CLEAR_ACC[13:7]) begin
      kind_o = K_CLEAR_ACCUM_INSTR;
    end else if (instr_i[13:11] == OP_CALL) begin
      kind_o = K_CALL;
    end else if (instr_i[13:8] == OP_CLEAR_REG && instr_i[DEST_BIT] == CLR_REG_D) begin
      kind_o = K_CLEAR_REG_INSTR;
    end else if (instr_i[13:8] == OP_COMPL) begin
      kind_o = K_COMPL;
    end else if (instr_i[13:8] == OP_DEC) begin
      kind_o = K_DEC;
    end else if (instr_i[13:8] == OP_DEC_SKIP) begin
      kind_o = K_DSKIP;
    end
  end
endmodule

// file: design/exec_subset.sv
// Purpose: execute the watchdog clear, call, complement, clear and decrement group
// Assumes: file register operand arrives with the instruction; inputs synchronous
// Notes:   accumulator and status bits live here; stack and watchdog are neighbours
// Summary of operation
// - watchdog clear zeroes counter and prescaler
// - watchdog clear sets timeout and powerdown flags
// - call pushes program counter plus one
// - call loads 11-bit immediate into pc low
// - call takes pc high from page latch
// - call takes two cycles
// - complement writes inverted register to destination
// - destination bit 0 accumulator, 1 register
// - clear register writes zero, sets zero flag
// - decrement writes register minus one
// - clear accumulator writes zero, sets zero
// - decrement-skip stores decrement to destination
// - zero result discards next, two cycles
module exec_subset
  import exec_subset_pkg::*;
(
  input  wire logic                       core_clk_i,       // instruction cycle clock
  input  wire logic                       resetn_i,         // async reset, active low
  input  wire logic                       instr_valid_i,    // instruction present this cycle
  input  wire logic [INSTR_W-1:0]         instr_i,          // instruction word
  input  wire logic [DATA_W-1:0]          freg_data_i,      // addressed register contents
  input  wire logic [DATA_W-1:0]          page_latch_i,     // page latch register
  input  wire logic [PC_W-1:0]            pc_i,             // current program counter
  output logic                            busy_o,           // second cycle in progress
  output logic                            watchdog_clear_o, // clears counter and prescaler
  output logic                            stack_push_o,     // push strobe
  output logic [PC_W-1:0]                 stack_top_o,      // return address pushed
  output logic                            pc_load_o,        // pc load strobe
  output logic [PC_W-1:0]                 pc_target_o,      // new pc value
  output logic                            freg_we_o,        // register write strobe
  output logic [FADDR_W-1:0]              freg_addr_o,      // register write address
  output logic [DATA_W-1:0]               freg_wdata_o,     // register write data
  output logic [DATA_W-1:0]               accum_o,          // accumulator
  output logic                            zero_flag_o,      // zero status
  output logic                            timeout_flag_o,   // timeout status
  output logic                            powerdown_flag_o  // powerdown status
);
  instr_kind_t kind;
  exec_state_t state;
  exec_state_t next_state;
  logic        take;
  logic        dest_reg;
  logic [DATA_W-1:0] result;
  logic        writes_result;
  logic        sets_zero;

  exec_subset_decode u_decode (
    .instr_i (instr_i),
    .kind_o  (kind)
  );

  // new instructions are ignored while the flush cycle runs
  assign take     = instr_valid_i && (state == ST_EXEC);
  assign dest_reg = instr_i[DEST_BIT];
  assign busy_o   = (state == ST_FLUSH);

  always_comb begin
    result        = ZERO_BYTE;
    writes_result = 1'b0;
    sets_zero     = 1'b0;
    unique case (kind)
      K_COMPL: begin
        result        = ~freg_data_i;
        writes_result = 1'b1;
        sets_zero     = 1'b1;
      end
      K_DEC, K_DSKIP: begin
        result        = freg_data_i - ONE_BYTE;
        writes_result = 1'b1;
        sets_zero     = (kind == K_DEC);
      end
      K_CLEAR_REG_INSTR, K_CLEAR_ACCUM_INSTR: begin
        result        = ZERO_BYTE;
        writes_result = 1'b1;
        sets_zero     = 1'b1;
      end
      K_NONE, K_WDT, K_CALL: begin
        result        = ZERO_BYTE;
        writes_result = 1'b0;
        sets_zero     = 1'b0;
      end
    endcase
  end

  // call and a taken skip spend one more cycle discarding the fetched word
  always_comb begin
    next_state = ST_EXEC;
    if (take && kind == K_CALL) begin
      next_state = ST_FLUSH;
    end else if (take && kind == K_DSKIP && result == ZERO_BYTE) begin
      next_state = ST_FLUSH;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_EXEC;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      accum_o      <= ZERO_BYTE;
      freg_we_o    <= 1'b0;
      freg_addr_o  <= '0;
      freg_wdata_o <= ZERO_BYTE;
    end else begin
      freg_we_o <= 1'b0;
      if (take && writes_result) begin
        if (kind == K_CLEAR_ACCUM_INSTR || (kind != K_CLEAR_REG_INSTR && !dest_reg)) begin
          accum_o <= result;
        end else begin
          freg_we_o    <= 1'b1;
          freg_addr_o  <= instr_i[FADDR_W-1:0];
          freg_wdata_o <= result;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      zero_flag_o      <= 1'b0;
      timeout_flag_o   <= 1'b1;
      powerdown_flag_o <= 1'b1;
    end else if (take) begin
      if (sets_zero) begin
        zero_flag_o <= (result == ZERO_BYTE);
      end
      if (kind == K_WDT) begin
        timeout_flag_o   <= 1'b1;
        powerdown_flag_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      watchdog_clear_o <= 1'b0;
      stack_push_o     <= 1'b0;
      stack_top_o      <= PC_RESET;
      pc_load_o        <= 1'b0;
      pc_target_o      <= PC_RESET;
    end else begin
      watchdog_clear_o <= take && (kind == K_WDT);
      stack_push_o     <= 1'b0;
      pc_load_o        <= 1'b0;
      if (take && kind == K_CALL) begin
        stack_push_o <= 1'b1;
        stack_top_o  <= pc_i + PC_ONE;
        pc_load_o    <= 1'b1;
        pc_target_o  <= {page_latch_i[PAGE_HI_BIT:PAGE_LO_BIT],
                         instr_i[CALL_K_W-1:0]};
      end
    end
  end
endmodule

// file: sim/exec_subset_chk.sv
// Purpose: port-level assertions for exec_subset
// Assumes: decode map of exec_subset_pkg
// Notes:   bound into every exec_subset instance
module exec_subset_chk
  import exec_subset_pkg::*;
(
  input logic                 core_clk_i, resetn_i, instr_valid_i, busy_o,
  input logic                 watchdog_clear_o, stack_push_o, pc_load_o,
  input logic                 zero_flag_o, timeout_flag_o, powerdown_flag_o,
  input logic [INSTR_W-1:0]   instr_i,
  input logic [DATA_W-1:0]    freg_data_i, page_latch_i, accum_o,
  input logic [PC_W-1:0]      pc_i, stack_top_o, pc_target_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic take, call, dsk;
  assign take = instr_valid_i && !busy_o;
  assign call = take && instr_i[13:11] == OP_CALL;
  assign dsk  = take && instr_i[13:8] == OP_DEC_SKIP;
  a_wdt_clear_pulse: assert property (take && instr_i == OP_WDT_CLEAR |=> watchdog_clear_o)
    else $error("watchdog clear missing");
  a_wdt_flags_set: assert property (take && instr_i == OP_WDT_CLEAR |=> timeout_flag_o && powerdown_flag_o)
    else $error("status flags not set");
  a_call_push_addr: assert property (call |=> stack_push_o && stack_top_o == $past(pc_i) + PC_ONE)
    else $error("bad return push");
  a_call_target_low: assert property (call |=> pc_load_o && pc_target_o[10:0] == $past(instr_i[10:0]))
    else $error("bad call target");
  a_call_page_bits: assert property (call |=> pc_target_o[12:11] == $past(page_latch_i[4:3]))
    else $error("bad page bits");
  a_call_two_cycle: assert property (call |=> busy_o ##1 !busy_o)
    else $error("call length wrong");
  a_clr_accum_zero: assert property (take && instr_i[13:7] == OP_CLEAR_ACC[13:7] |=> accum_o == 8'h00 && zero_flag_o)
    else $error("accum not cleared");
  a_skip_flush: assert property (dsk |=> busy_o == ($past(freg_data_i) == 8'h01))
    else $error("skip slot wrong");
  a_skip_flags_kept: assert property (dsk |=> $stable(zero_flag_o))
    else $error("skip changed zero");
  c_call: cover property (call);
  c_skip: cover property (dsk && freg_data_i == 8'h01);
  c_wdt: cover property (take && instr_i == OP_WDT_CLEAR);
endmodule
bind exec_subset exec_subset_chk u_chk (.*);

// file: sim/exec_subset_test.sv
// Purpose: self-checking bench for exec_subset
// Assumes: inputs change on falling edge, results read one cycle later, at the next falling edge
// Notes:   expectations come from a small reference of the register ops
module exec_subset_test;
  timeunit 1ns;
  timeprecision 1ns;
  import exec_subset_pkg::*;
  logic        core_clk_i = 0, resetn_i = 0, instr_valid_i = 0;
  logic [13:0] instr_i = '0;
  logic [7:0]  freg_data_i = '0, page_latch_i = '0, accum_o, freg_wdata_o, acc = '0, r;
  logic [12:0] pc_i = '0, stack_top_o, pc_target_o;
  logic [6:0]  freg_addr_o;
  logic        busy_o, watchdog_clear_o, stack_push_o, pc_load_o, freg_we_o;
  logic        zero_flag_o, timeout_flag_o, powerdown_flag_o, z = 0, sk;
  logic [5:0]  ops [4] = '{OP_COMPL, OP_CLEAR_REG, OP_DEC, OP_DEC_SKIP};
  int          n_fail = 0, cmp_count = 0;
  always #50 core_clk_i = ~core_clk_i;
  exec_subset u_dut (.*);
  task chk(string s, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task send(logic [13:0] w, logic [7:0] f, logic v);
    instr_i = w;
    freg_data_i = f;
    instr_valid_i = v;
    @(negedge core_clk_i);
  endtask
  task op(logic [13:0] w, logic [7:0] f);
    r = (w[13:8] == OP_COMPL) ? ~f : (w[13:8] == OP_CLEAR_REG) ? 8'h00 : f - 8'h01;
    sk = w[13:8] == OP_DEC_SKIP && r == 8'h00;
    if (w[13:8] != OP_DEC_SKIP) z = r == 8'h00;
    if (!w[DEST_BIT]) acc = r;
    send(w, f, 1);
    chk("accum", acc, accum_o);
    chk("we", w[DEST_BIT], freg_we_o);
    if (w[DEST_BIT]) chk("wdata", {w[6:0], r}, {freg_addr_o, freg_wdata_o});
    chk("zero", z, zero_flag_o);
    chk("busy", sk, busy_o);
    if (sk) send(OP_WDT_CLEAR, f, 1);
    if (sk) chk("flush", 0, {busy_o, watchdog_clear_o});
  endtask
  task call(logic [10:0] k, logic [7:0] pl, logic [12:0] pc);
    page_latch_i = pl;
    pc_i = pc;
    send({OP_CALL, k}, 0, 1);
    chk("push", {pc + 13'h1, 3'h7}, {stack_top_o, stack_push_o, pc_load_o, busy_o});
    chk("target", {pl[4:3], k}, pc_target_o);
    send(OP_CLEAR_ACC, 0, 1);
    chk("flush", {acc, 2'b0}, {accum_o, stack_push_o, busy_o});
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hcffeac26));
    repeat (4) @(negedge core_clk_i);
    chk("reset", 16'h0600, {timeout_flag_o, powerdown_flag_o, zero_flag_o, accum_o});
    resetn_i = 1;
    send(OP_WDT_CLEAR, 0, 1);
    chk("wdt", 16'h7, {watchdog_clear_o, timeout_flag_o, powerdown_flag_o});
    op({OP_DEC, 8'h05}, 8'h01);
    op({OP_DEC, 8'h85}, 8'h00);
    op({OP_COMPL, 8'h00}, 8'hff);
    op({OP_DEC_SKIP, 8'h12}, 8'h01);
    op({OP_DEC_SKIP, 8'h93}, 8'h05);
    op({OP_CLEAR_REG, 8'h80}, 8'h5a);
    op({OP_CLEAR_REG, 8'h00}, 8'h33);
    repeat (60) op({ops[$urandom_range(3)], 8'($urandom)}, 8'($urandom_range(3) ? $urandom : 1));
    op({OP_DEC, 8'h00}, 8'h80);
    call(11'($urandom), 8'($urandom), 13'($urandom));
    call(11'h7ff, 8'h18, 13'h1fff);
    results;
  end
endmodule
